// ### hw/uefc_core.sv
// enhanced flow-control, gate and reset-state logic of one serial channel
//
// How it works
// RULE1: special detect matches second pause, stores, flags
// RULE2: character register bit 0 aligns with LSB
// RULE3: software keeps rx flow off during detect
// RULE4: gate open lets enhanced bits be written
// RULE5: gate closed hides enhanced bits as zero
// RULE6: reopening gate restores the saved bits
// RULE7: flow select bits reset to none
// RULE8: tx select picks first, second or dual
// RULE9: rx select compares first, second or both
// RULE10: peers never send flow codes as data
// RULE11: dual mode treats pairs as one sequence
// RULE12: reset clears control, status reads no-interrupt
// RULE13: reset line status reads transmitter empty
// RULE14: reset modem status follows pins, deltas clear
// RULE15: reset drives line outputs high, irq floating
// RULE16: pause char stops tx, resume restarts it
//
// The register offsets and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module uefc_core
    import uefc_pkg::*;
(
    input  wire logic        mclk_i,
    input  wire logic        reset_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    input  wire logic        rx_char_valid_i,
    input  wire logic [7:0]  rx_char_i,
    output logic             rx_store_valid_o,
    output logic      [7:0]  rx_store_char_o,
    input  wire logic        tx_need_pause_i,
    input  wire logic        tx_need_resume_i,
    output logic             tx_flow_valid_o,
    output logic      [7:0]  tx_flow_char_o,
    input  wire logic        tx_flow_ready_i,
    output logic             tx_pause_o,
    input  wire logic [3:0]  modem_n_i,
    input  wire logic        tx_serial_i,
    output logic      [7:0]  interrupt_enable_o,
    output logic      [7:0]  fifo_control_o,
    output logic      [7:0]  line_control_o,
    output logic             serial_out_o,
    output logic             user_output_two_o,
    output logic             request_send_out_o,
    output logic             terminal_ready_out_o,
    output logic             irq_out_o,
    output logic             irq_out_oe_o
);
    // ==========================================================
    // helpers
    function automatic logic [7:0] gated_wr(input logic [7:0] cur, input logic [7:0] wd,
                                            input logic [7:0] msk, input logic gate);
        gated_wr = gate ? wd : ((cur & msk) | (wd & ~msk));
    endfunction : gated_wr

    function automatic logic [7:0] gated_rd(input logic [7:0] cur, input logic [7:0] msk,
                                            input logic gate);
        gated_rd = gate ? cur : (cur & ~msk); // [RULE5] [RULE6]
    endfunction : gated_rd

    function automatic logic flow_hit(input logic [1:0] sel, input logic [7:0] c,
                                      input logic [7:0] f, input logic [7:0] s,
                                      input logic prev_f);
        case (sel)
            SEL_FIRST:  flow_hit = (c == f);
            SEL_SECOND: flow_hit = (c == s);
            SEL_BOTH:   flow_hit = prev_f && (c == s);
            default:    flow_hit = 1'b0;
        endcase
    endfunction : flow_hit

    // ==========================================================
    // state
    logic [7:0]       ier_ff, fcr_ff, lcr_ff, mcr_ff, lsr_ff, efc_ff, isr_ff;
    logic [7:0]       res1_ff, res2_ff, pau1_ff, pau2_ff;
    logic [7:0]       nxt_ier, nxt_fcr, nxt_lcr, nxt_mcr, nxt_lsr, nxt_efc, nxt_isr;
    logic [7:0]       nxt_res1, nxt_res2, nxt_pau1, nxt_pau2;
    logic [IRQ_W-1:0] istat_ff, imask_ff, nxt_istat, nxt_imask, ev;
    logic [3:0]       delta_ff, nxt_delta, sync1_ff, sync2_ff, prev_ff;
    logic [31:0]      prdata_ff, nxt_prdata, rd_mux;
    logic [7:0]       isr_view, mcr_view, msr_view;
    logic             gate, acc, wr, rd, addr_ok, special_hit, pause_hit, resume_hit;
    logic             pause_ff, nxt_pause, prev_p1_ff, nxt_prev_p1, prev_r1_ff, nxt_prev_r1;
    logic             store_v_ff, nxt_store_v;
    logic [7:0]       store_c_ff, nxt_store_c;
    uefc_txst_t       txst_ff, nxt_txst;
    logic [1:0]       txsel_ff, nxt_txsel;
    logic             kind_ff, nxt_kind;
    logic [7:0]       txc_ff, nxt_txc;
    logic [5:0]       pin_ff, nxt_pin;

    assign gate     = efc_ff[EFC_GATE];
    assign acc      = psel_i && penable_i;
    assign wr       = acc && pwrite_i;
    assign rd       = acc && !pwrite_i;
    assign addr_ok  = (paddr_i[1:0] == 2'b00) && (paddr_i <= OFS_LAST);
    // zero wait states keep the bus side trivial; read data is set up in the setup phase
    assign pready_o  = 1'b1;
    assign pslverr_o = acc && !addr_ok;
    assign prdata_o  = prdata_ff;

    assign interrupt_enable_o = gated_rd(ier_ff, IER_ENH, gate);                // [RULE5]
    assign fifo_control_o     = gated_rd(fcr_ff, FCR_ENH, gate);                // [RULE5]
    assign mcr_view           = gated_rd(mcr_ff, MCR_ENH, gate);                // [RULE5]
    assign line_control_o     = lcr_ff;
    assign isr_view = {gated_rd(isr_ff, ISR_ENH, gate)} | {7'h00, !irq_out_o};  // [RULE12]
    assign msr_view = {~sync2_ff, delta_ff};                                    // [RULE14]

    assign special_hit = rx_char_valid_i && efc_ff[EFC_SPECIAL]
                         && (rx_char_i == pau2_ff);                  // [RULE1] [RULE2]
    assign pause_hit  = rx_char_valid_i
        && flow_hit(efc_ff[EFC_RX_LSB+:2], rx_char_i, pau1_ff, pau2_ff, prev_p1_ff); // [RULE9]
    assign resume_hit = rx_char_valid_i
        && flow_hit(efc_ff[EFC_RX_LSB+:2], rx_char_i, res1_ff, res2_ff, prev_r1_ff); // [RULE11]
    // modem event taken from the flops, not from nxt_delta, so no loop through regs_next
    assign ev = {(|(sync2_ff ^ prev_ff)) & ~(|delta_ff), resume_hit, pause_hit, special_hit};

    // ==========================================================
    // registers and bus
    always_comb begin : regs_next
        nxt_ier   = ier_ff;
        nxt_fcr   = fcr_ff;
        nxt_lcr   = lcr_ff;
        nxt_mcr   = mcr_ff;
        nxt_efc   = efc_ff;
        nxt_isr   = isr_ff;
        nxt_lsr   = lsr_ff;
        nxt_res1  = res1_ff;
        nxt_res2  = res2_ff;
        nxt_pau1  = pau1_ff;
        nxt_pau2  = pau2_ff;
        nxt_istat = istat_ff;
        nxt_imask = imask_ff;
        nxt_delta = delta_ff;
        rd_mux    = 32'h0000_0000;
        case (paddr_i)
            OFS_IER:   rd_mux[7:0] = interrupt_enable_o;
            OFS_ISR:   rd_mux[7:0] = isr_view;
            OFS_FCR:   rd_mux[7:0] = fifo_control_o;
            OFS_LCR:   rd_mux[7:0] = lcr_ff;
            OFS_MCR:   rd_mux[7:0] = mcr_view;
            OFS_LSR:   rd_mux[7:0] = lsr_ff;
            OFS_MSR:   rd_mux[7:0] = msr_view;
            OFS_EFC:   rd_mux[7:0] = efc_ff;
            OFS_RES1:  rd_mux[7:0] = res1_ff;
            OFS_RES2:  rd_mux[7:0] = res2_ff;
            OFS_PAU1:  rd_mux[7:0] = pau1_ff;
            OFS_PAU2:  rd_mux[7:0] = pau2_ff;
            OFS_ISTAT: rd_mux[IRQ_W-1:0] = istat_ff;
            OFS_IMASK: rd_mux[IRQ_W-1:0] = imask_ff;
            OFS_FLOW:  rd_mux[1:0] = {tx_flow_valid_o, pause_ff};
            default:   rd_mux = 32'h0000_0000;
        endcase
        nxt_prdata = (psel_i && !penable_i) ? rd_mux : prdata_ff;
        if (wr) begin
            case (paddr_i)
                OFS_IER:   nxt_ier = gated_wr(ier_ff, pwdata_i[7:0], IER_ENH, gate); // [RULE4]
                OFS_ISR:   nxt_isr = gated_wr(isr_ff, pwdata_i[7:0] & ISR_ENH,
                                              ISR_ENH, gate);                        // [RULE4]
                OFS_FCR:   nxt_fcr = gated_wr(fcr_ff, pwdata_i[7:0], FCR_ENH, gate); // [RULE4]
                OFS_LCR:   nxt_lcr = pwdata_i[7:0];
                OFS_MCR:   nxt_mcr = gated_wr(mcr_ff, pwdata_i[7:0], MCR_ENH, gate); // [RULE4]
                OFS_EFC:   nxt_efc = pwdata_i[7:0];
                OFS_RES1:  nxt_res1 = pwdata_i[7:0];
                OFS_RES2:  nxt_res2 = pwdata_i[7:0];
                OFS_PAU1:  nxt_pau1 = pwdata_i[7:0];
                OFS_PAU2:  nxt_pau2 = pwdata_i[7:0];
                OFS_ISTAT: nxt_istat = istat_ff & ~pwdata_i[IRQ_W-1:0];
                OFS_IMASK: nxt_imask = pwdata_i[IRQ_W-1:0];
                default:   ;
            endcase
        end
        // reads that consume status; hardware sets below win over these clears
        if (rd && paddr_i == OFS_MSR) nxt_delta = 4'h0;
        if (rd && paddr_i == OFS_LSR) nxt_lsr[0] = 1'b0;
        nxt_delta = nxt_delta | (sync2_ff ^ prev_ff);
        if (nxt_store_v) nxt_lsr[0] = 1'b1;
        if (special_hit) nxt_isr[ISR_SPECIAL] = 1'b1;                       // [RULE1]
        nxt_istat = nxt_istat | ev;
    end

    always_ff @(posedge mclk_i) begin : regs_ff
        if (reset_i) begin
            ier_ff   <= RST_REG;                                            // [RULE12]
            fcr_ff   <= RST_REG;
            lcr_ff   <= RST_REG;
            mcr_ff   <= RST_REG;
            isr_ff   <= RST_REG;
            lsr_ff   <= RST_LSR;                                            // [RULE13]
            efc_ff   <= RST_REG;                                            // [RULE7]
            res1_ff  <= RST_CHAR;
            res2_ff  <= RST_CHAR;
            pau1_ff  <= RST_CHAR;
            pau2_ff  <= RST_CHAR;
            istat_ff <= '0;
            imask_ff <= '0;
            delta_ff <= 4'h0;                                               // [RULE14]
            prdata_ff <= 32'h0000_0000;
        end else begin
            ier_ff   <= nxt_ier;
            fcr_ff   <= nxt_fcr;
            lcr_ff   <= nxt_lcr;
            mcr_ff   <= nxt_mcr;
            isr_ff   <= nxt_isr;
            lsr_ff   <= nxt_lsr;
            efc_ff   <= nxt_efc;
            res1_ff  <= nxt_res1;
            res2_ff  <= nxt_res2;
            pau1_ff  <= nxt_pau1;
            pau2_ff  <= nxt_pau2;
            istat_ff <= nxt_istat;
            imask_ff <= nxt_imask;
            delta_ff <= nxt_delta;
            prdata_ff <= nxt_prdata;
        end
    end

    // ==========================================================
    // modem pin synchroniser; runs through reset so status shows live pins
    always_ff @(posedge mclk_i) begin : sync_ff
        sync1_ff <= modem_n_i;
        sync2_ff <= sync1_ff;
        prev_ff  <= sync2_ff;
    end

    // ==========================================================
    // receive flow control
    always_comb begin : rx_next
        nxt_pause   = pause_ff;
        nxt_prev_p1 = prev_p1_ff;
        nxt_prev_r1 = prev_r1_ff;
        if (rx_char_valid_i) begin
            nxt_prev_p1 = (rx_char_i == pau1_ff);                           // [RULE11]
            nxt_prev_r1 = (rx_char_i == res1_ff);
        end
        if (resume_hit) nxt_pause = 1'b0;                                   // [RULE16]
        if (pause_hit) nxt_pause = 1'b1;                                    // [RULE16]
        // a completing flow character is consumed, never handed to the fifo
        nxt_store_v = rx_char_valid_i && !pause_hit && !resume_hit;         // [RULE16]
        nxt_store_c = rx_char_valid_i ? rx_char_i : store_c_ff;
    end

    always_ff @(posedge mclk_i) begin : rx_ff
        if (reset_i) begin
            pause_ff   <= 1'b0;
            prev_p1_ff <= 1'b0;
            prev_r1_ff <= 1'b0;
            store_v_ff <= 1'b0;
            store_c_ff <= RST_CHAR;
        end else begin
            pause_ff   <= nxt_pause;
            prev_p1_ff <= nxt_prev_p1;
            prev_r1_ff <= nxt_prev_r1;
            store_v_ff <= nxt_store_v;
            store_c_ff <= nxt_store_c;
        end
    end
    assign tx_pause_o       = pause_ff;
    assign rx_store_valid_o = store_v_ff;
    assign rx_store_char_o  = store_c_ff;

    // ==========================================================
    // transmit flow characters; requests while busy are dropped
    always_comb begin : tx_next
        nxt_txst  = txst_ff;
        nxt_txsel = txsel_ff;
        nxt_kind  = kind_ff;
        nxt_txc   = txc_ff;
        unique case (txst_ff)
            TX_IDLE: begin
                if ((tx_need_pause_i || tx_need_resume_i)
                    && efc_ff[EFC_TX_LSB+:2] != SEL_NONE) begin             // [RULE8]
                    nxt_txsel = efc_ff[EFC_TX_LSB+:2];
                    nxt_kind  = tx_need_pause_i;
                    nxt_txst  = TX_FIRST;
                    if (efc_ff[EFC_TX_LSB+:2] == SEL_SECOND)
                        nxt_txc = tx_need_pause_i ? pau2_ff : res2_ff;
                    else
                        nxt_txc = tx_need_pause_i ? pau1_ff : res1_ff;
                end
            end
            TX_FIRST: begin
                if (tx_flow_ready_i) begin
                    nxt_txst = (txsel_ff == SEL_BOTH) ? TX_SECOND : TX_IDLE; // [RULE11]
                    nxt_txc  = kind_ff ? pau2_ff : res2_ff;
                end
            end
            TX_SECOND: begin
                if (tx_flow_ready_i) nxt_txst = TX_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk_i) begin : tx_ff
        if (reset_i) begin
            txst_ff  <= TX_IDLE;
            txsel_ff <= SEL_NONE;
            kind_ff  <= 1'b0;
            txc_ff   <= RST_CHAR;
        end else begin
            txst_ff  <= nxt_txst;
            txsel_ff <= nxt_txsel;
            kind_ff  <= nxt_kind;
            txc_ff   <= nxt_txc;
        end
    end
    assign tx_flow_valid_o = (txst_ff != TX_IDLE);
    assign tx_flow_char_o  = txc_ff;

    // ==========================================================
    // line pins: serial, op2, rts, dtr, irq, irq enable
    always_comb begin : pin_next
        nxt_pin = {tx_serial_i, !mcr_view[MCR_OP2], !mcr_view[MCR_RTS],
                   !mcr_view[MCR_DTR], |(istat_ff & imask_ff), 1'b1};
    end

    always_ff @(posedge mclk_i) begin : pin_ff_p
        if (reset_i) pin_ff <= 6'b111100;                                   // [RULE15]
        else pin_ff <= nxt_pin;
    end
    assign {serial_out_o, user_output_two_o, request_send_out_o,
            terminal_ready_out_o, irq_out_o, irq_out_oe_o} = pin_ff;

    // ==========================================================
    // assertions
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (reset_i);

    property p_special;
        special_hit |=> rx_store_valid_o && isr_ff[ISR_SPECIAL];
    endproperty
    a_special: assert property (p_special) else $error("special char lost"); // [RULE1]
    property p_lsb;
        rx_char_valid_i && efc_ff[EFC_SPECIAL] && rx_char_i[0] != pau2_ff[0]
            && !isr_ff[ISR_SPECIAL] && !(wr && paddr_i == OFS_ISR) |=> !isr_ff[ISR_SPECIAL];
    endproperty
    a_lsb: assert property (p_lsb) else $error("lsb mismatch flagged");       // [RULE2]
    property p_gate_wr;
        wr && paddr_i == OFS_IER && gate |=> ier_ff[7:4] == $past(pwdata_i[7:4]);
    endproperty
    a_gate_wr: assert property (p_gate_wr) else $error("gated write lost");   // [RULE4]
    property p_gate_hide;
        !gate |-> (interrupt_enable_o & IER_ENH) == 8'h00 && (mcr_view & MCR_ENH) == 8'h00;
    endproperty
    a_gate_hide: assert property (p_gate_hide) else $error("hidden bits shown"); // [RULE5]
    property p_restore;
        $rose(gate) && $stable(ier_ff) |-> interrupt_enable_o == $past(ier_ff);
    endproperty
    a_restore: assert property (p_restore) else $error("saved bits lost");   // [RULE6]
    property p_reset_regs;
        $fell(reset_i) |-> efc_ff == 8'h00 && ier_ff == 8'h00 && isr_view == 8'h01
            && lsr_ff == RST_LSR && delta_ff == 4'h0;
    endproperty
    a_reset_regs: assert property (p_reset_regs) else $error("bad reset regs"); // [RULE12]
    property p_reset_pins;
        $fell(reset_i) |-> serial_out_o && user_output_two_o && request_send_out_o
            && terminal_ready_out_o && !irq_out_oe_o;
    endproperty
    a_reset_pins: assert property (p_reset_pins) else $error("bad reset pins"); // [RULE15]
    property p_tx_dual;
        txst_ff == TX_FIRST && tx_flow_ready_i && txsel_ff == SEL_BOTH
            |=> tx_flow_valid_o && tx_flow_char_o == (kind_ff ? pau2_ff : res2_ff);
    endproperty
    a_tx_dual: assert property (p_tx_dual) else $error("second char missing"); // [RULE8]
    property p_pause;
        pause_hit |=> tx_pause_o && !rx_store_valid_o;
    endproperty
    a_pause: assert property (p_pause) else $error("pause not taken");         // [RULE16]
    property p_resume;
        resume_hit && !pause_hit |=> !tx_pause_o;
    endproperty
    a_resume: assert property (p_resume) else $error("resume not taken");      // [RULE9]
    property p_irq;
        |(istat_ff & imask_ff) |=> irq_out_o;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt not raised");
    c_special: cover property (special_hit);
    c_pause_resume: cover property (pause_hit ##[1:50] resume_hit);
    c_dual_tx: cover property (txst_ff == TX_SECOND);
    c_gate: cover property ($rose(gate));
endmodule : uefc_core

// ### hw/uefc_pkg.sv
// constants for the enhanced flow-control register block
package uefc_pkg;
    localparam logic [7:0] OFS_IER   = 8'h00;
    localparam logic [7:0] OFS_ISR   = 8'h04;
    localparam logic [7:0] OFS_FCR   = 8'h08;
    localparam logic [7:0] OFS_LCR   = 8'h0c;
    localparam logic [7:0] OFS_MCR   = 8'h10;
    localparam logic [7:0] OFS_LSR   = 8'h14;
    localparam logic [7:0] OFS_MSR   = 8'h18;
    localparam logic [7:0] OFS_EFC   = 8'h1c;
    localparam logic [7:0] OFS_RES1  = 8'h20;
    localparam logic [7:0] OFS_RES2  = 8'h24;
    localparam logic [7:0] OFS_PAU1  = 8'h28;
    localparam logic [7:0] OFS_PAU2  = 8'h2c;
    localparam logic [7:0] OFS_ISTAT = 8'h30;
    localparam logic [7:0] OFS_IMASK = 8'h34;
    localparam logic [7:0] OFS_FLOW  = 8'h38;
    localparam logic [7:0] OFS_LAST  = 8'h38;
    // enhanced feature control fields, then isr and mcr bit positions
    localparam int EFC_SPECIAL = 5;
    localparam int EFC_GATE    = 4;
    localparam int EFC_TX_LSB  = 2;
    localparam int EFC_RX_LSB  = 0;
    localparam int ISR_SPECIAL = 4;
    localparam int MCR_DTR     = 0;
    localparam int MCR_RTS     = 1;
    localparam int MCR_OP2     = 3;
    // bit groups hidden while the gate is closed
    localparam logic [7:0] IER_ENH = 8'hf0;
    localparam logic [7:0] ISR_ENH = 8'h30;
    localparam logic [7:0] FCR_ENH = 8'h30;
    localparam logic [7:0] MCR_ENH = 8'he0;
    // reset values
    localparam logic [7:0] RST_REG  = 8'h00;
    localparam logic [7:0] RST_LSR  = 8'h60;
    localparam logic [7:0] RST_CHAR = 8'h00;
    // flow select codes, same for the tx and rx pairs
    localparam logic [1:0] SEL_NONE   = 2'b00;
    localparam logic [1:0] SEL_FIRST  = 2'b10;
    localparam logic [1:0] SEL_SECOND = 2'b01;
    localparam logic [1:0] SEL_BOTH   = 2'b11;
    // interrupt status / mask bits
    localparam int IRQ_W       = 4;
    localparam int IRQ_SPECIAL = 0;
    localparam int IRQ_PAUSE   = 1;
    localparam int IRQ_RESUME  = 2;
    localparam int IRQ_MODEM   = 3;
    typedef enum logic [1:0] {TX_IDLE, TX_FIRST, TX_SECOND} uefc_txst_t;
endpackage : uefc_pkg

// ### verification/uefc_remote.sv
// remote serial port model that trades flow-control characters
`timescale 1ns/1ps
module uefc_remote (
    input  wire logic       mclk_i,
    input  wire logic [3:0] stall_i,
    input  wire logic       flow_valid_i,
    input  wire logic [7:0] flow_char_i,
    output logic            flow_ready_o,
    output logic            rx_valid_o,
    output logic [7:0]      rx_char_o
);
    logic [7:0] got_q[$];
    logic [3:0] wait_cnt = 4'h0;
    initial flow_ready_o = 1'b0;
    initial rx_valid_o = 1'b0;
    initial rx_char_o = 8'h00;
    // =========
    // acceptance
    // ready only after the stall, so slow takers are exercised too
    always @(posedge mclk_i) begin
        if (flow_valid_i && flow_ready_o) begin
            got_q.push_back(flow_char_i);
            flow_ready_o <= 1'b0;
            wait_cnt <= 4'h0;
        end else if (flow_valid_i) begin
            wait_cnt <= wait_cnt + 4'h1;
            flow_ready_o <= (wait_cnt >= stall_i);
        end
    end
    // callers keep payload bytes apart from the flow codes
    task automatic send(input logic [7:0] c);
        @(posedge mclk_i);
        rx_valid_o <= 1'b1;
        rx_char_o <= c;
        @(posedge mclk_i);
        rx_valid_o <= 1'b0;
        rx_char_o <= ~c;
    endtask : send
endmodule : uefc_remote

// ### verification/uart_enhanced_flow_control_tb.sv
// register and flow-control tests of the enhanced flow-control block
`timescale 1ns/1ps
module uart_enhanced_flow_control_tb;
    import uefc_pkg::*;
    logic        clk = 1'b0;
    logic        rst, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0]  paddr, rxc, interrupt_enable_reg, e1, e2;
    logic [31:0] pwdata, prdata, q;
    logic        rxv, stv, needp, needr, fv, fr, pause, txs, sout, op2, rts, dtr, irq, oe;
    logic [7:0]  fc;
    logic [3:0]  modem_n, stall;
    logic [1:0]  sel;
    logic [7:0]  stc, fco, lco;
    int          fail_count = 0;
    int          check_count = 0;
    int          stores = 0;
    int          n;
    logic [7:0]  ra[8] = '{OFS_IER, OFS_ISR, OFS_FCR, OFS_LCR, OFS_MCR, OFS_LSR, OFS_MSR, OFS_EFC};
    logic [7:0]  rv[8] = '{8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h60, 8'ha0, 8'h00};
    always #12.5 clk = ~clk;
    always @(posedge clk) if (stv) stores <= stores + 1;
    uefc_core i_dut (.mclk_i(clk), .reset_i(rst), .paddr_i(paddr), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .rx_char_valid_i(rxv), .rx_char_i(rxc),
        .rx_store_valid_o(stv), .rx_store_char_o(stc), .tx_need_pause_i(needp),
        .tx_need_resume_i(needr), .tx_flow_valid_o(fv), .tx_flow_char_o(fc),
        .tx_flow_ready_i(fr), .tx_pause_o(pause), .modem_n_i(modem_n), .tx_serial_i(txs),
        .interrupt_enable_o(interrupt_enable_reg), .fifo_control_o(fco), .line_control_o(lco), .serial_out_o(sout),
        .user_output_two_o(op2), .request_send_out_o(rts), .terminal_ready_out_o(dtr),
        .irq_out_o(irq), .irq_out_oe_o(oe));
    uefc_remote i_rem (.mclk_i(clk), .stall_i(stall), .flow_valid_i(fv), .flow_char_i(fc),
        .flow_ready_o(fr), .rx_valid_o(rxv), .rx_char_o(rxc));
    // ==========
    // bus helpers
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : stop_test
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int k;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20) begin
            fail_count++;
            stop_test();
        end
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(a, 1'b1, d);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(a, 1'b0, 32'h0);
        check(q, exp);
    endtask : rd
    task automatic settle(input int c);
        repeat (c) @(posedge clk);
        #1;
    endtask : settle
    // ==========
    // main sequence
    initial begin
        {rst, psel, penable, pwrite, paddr, pwdata, needp, needr, txs, stall} = '0;
        rst = 1'b1;
        modem_n = 4'b0101;
        settle(3);
        check({27'h0, sout, op2, rts, dtr, oe}, 32'h1e);
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        settle(1);
        check({30'h0, oe, sout}, 32'h2);
        for (int i = 0; i < 8; i++) rd(ra[i], {24'h0, rv[i]});
        rd(8'h3c, 32'h0);
        check(32'(err), 32'h1);
        wr(OFS_IER, 32'hff);
        rd(OFS_IER, 32'h0f);
        wr(OFS_EFC, 32'h10);
        wr(OFS_IER, 32'hff);
        wr(OFS_MCR, 32'heb);
        rd(OFS_MCR, 32'heb);
        wr(OFS_EFC, 32'h00);
        rd(OFS_IER, 32'h0f);
        rd(OFS_MCR, 32'h0b);
        check({24'h0, interrupt_enable_reg}, 32'h0f);
        check({29'h0, op2, rts, dtr}, 32'h0);
        wr(OFS_EFC, 32'h10);
        rd(OFS_IER, 32'hff);
        wr(OFS_FCR, 32'h3c);
        wr(OFS_LCR, 32'h5a);
        // one modem pin moves: delta flag, modem interrupt, live pin view
        modem_n <= 4'b0100;
        txs <= 1'b1;
        wr(OFS_IMASK, 32'h8);
        settle(4);
        check({16'h0, fco, lco}, 32'h3c5a);
        check({30'h0, irq, sout}, 32'h3);
        rd(OFS_MSR, 32'hb1);
        rd(OFS_MSR, 32'hb0);
        wr(OFS_RES1, 32'h11);
        wr(OFS_RES2, 32'h91);
        wr(OFS_PAU1, 32'h13);
        wr(OFS_PAU2, 32'h93);
        wr(OFS_IMASK, 32'h2);
        wr(OFS_EFC, 32'h12);
        n = stores;
        i_rem.send(8'h12);
        i_rem.send(8'h13);
        settle(3);
        check(32'(pause), 32'h1);
        check(32'(stores), 32'(n + 1));
        check(32'(irq), 32'h1);
        wr(OFS_ISTAT, 32'hf);
        settle(2);
        check(32'(irq), 32'h0);
        i_rem.send(8'h11);
        i_rem.send(8'h93);
        settle(3);
        check(32'(pause), 32'h0);
        wr(OFS_EFC, 32'h13);
        i_rem.send(8'h13);
        i_rem.send(8'h93);
        settle(3);
        check(32'(pause), 32'h1);
        // special detect with receive flow control held off
        wr(OFS_EFC, 32'h30);
        n = stores;
        i_rem.send(8'h92);
        i_rem.send(8'h93);
        settle(3);
        check(32'(stores), 32'(n + 2));
        check({24'h0, stc}, 32'h93);
        apb(OFS_ISR, 1'b0, 32'h0);
        check(q & 32'h10, 32'h10);
        for (int m = 1; m < 4; m++) begin
            sel = 2'(m);
            stall = 4'(m);
            wr(OFS_EFC, {26'h0, 1'b1, 1'b0, sel, 2'b00});
            for (int kd = 0; kd < 2; kd++) begin
                e1 = kd ? 8'h11 : 8'h13;
                e2 = kd ? 8'h91 : 8'h93;
                i_rem.got_q.delete();
                @(posedge clk);
                needp <= (kd == 0);
                needr <= (kd == 1);
                @(posedge clk);
                needp <= 1'b0;
                needr <= 1'b0;
                settle(40);
                check(32'(i_rem.got_q.size()), (sel == SEL_BOTH) ? 32'h2 : 32'h1);
                check({24'h0, i_rem.got_q[0]}, {24'h0, sel[1] ? e1 : e2});
                if (sel == SEL_BOTH) check({24'h0, i_rem.got_q[1]}, {24'h0, e2});
            end
        end
        stop_test();
    end
endmodule : uart_enhanced_flow_control_tb
